// [dsp_sram_port.sv]
// Two-word burst double-data-rate SRAM port, device side.
// Assumes core_clk_i oversamples all link clocks; every pin passes two flops.
// How it works
// - Low lane enable at a data edge stores that byte or nibble.
// - Lane count follows organization: x8 two, x9 one, x18 two, x36 four.
// - Address and control taken on input_timing_pos rise; data on both rises.
// - First read word timed by output_timing_neg, second by output_timing_pos.
// - Output clocks held high means read words follow input clock rises.
// - Echo strobes follow the timing clock, also while data floats.
// - Echo strobes stop whenever the timing clock pair stops.
// - Low delay_lock_disable_n bypasses the delay loop; logic behaves alike.
// - Unconnected ball levels belong to scan, which this block omits.
// - Second burst word address is the start bit inverted.
// - Write data words come at pos then neg rise of next cycle.
// - Read words leave at neg rise t then pos rise t+1.
// - Data bus floats from reset until a read drives it.
// - Every transaction moves exactly two words.
// - High load_strobe_n is a no-operation; address ignored.
// - burst_start_bit is the lowest address bit on x18 and x36.
`include "dsp_defs.svh"
`default_nettype none
module dsp_sram_port #(
   parameter int ADDR_W = `DSP_ADDR_W,
   parameter int ORG_BITS = `DSP_DATA_W,
   parameter int LANES = `DSP_LANES
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Link clocks and delay-loop disable
   input wire logic input_timing_pos_i,
   input wire logic input_timing_neg_i,
   input wire logic output_timing_pos_i,
   input wire logic output_timing_neg_i,
   input wire logic delay_lock_disable_n_i,
   // Command
   input wire logic load_strobe_n_i,
   input wire logic read_not_write_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic burst_start_bit_i,
   input wire logic [LANES-1:0] byte_write_enable_n_i,
   // Data bus
   input wire logic [ORG_BITS-1:0] dq_i,
   output logic [ORG_BITS-1:0] dq_o,
   output logic dq_oe_o,
   // Echo strobes
   output logic data_valid_strobe_pos_o,
   output logic data_valid_strobe_neg_o,
   // Status
   output logic dll_bypass_o
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam int NS = 6 + ADDR_W + LANES + ORG_BITS;
   logic [NS-1:0] s1_reg, s2_reg, s3_reg;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= {input_timing_pos_i, input_timing_neg_i, output_timing_pos_i, output_timing_neg_i,
                    load_strobe_n_i, read_not_write_i, addr_i, byte_write_enable_n_i, dq_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   logic [ORG_BITS-1:0] d_s;
   logic [LANES-1:0] we_n_s;
   logic [ADDR_W-1:0] a_s;
   logic ld_n_s, rw_s;
   assign d_s = s2_reg[ORG_BITS-1:0];
   assign we_n_s = s2_reg[ORG_BITS +: LANES];
   assign a_s = s2_reg[ORG_BITS+LANES +: ADDR_W];
   assign rw_s = s2_reg[NS-6];
   assign ld_n_s = s2_reg[NS-5];
   // Edge detection waits until all three sampling stages hold real pin levels
   logic [1:0] warm_reg, warm_next;
   logic warm;
   assign warm_next = (warm_reg == 2'd3) ? warm_reg : warm_reg + 2'd1;
   assign warm = (warm_reg == 2'd3);
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         warm_reg <= 2'd0;
      end else begin
         warm_reg <= warm_next;
      end
   end
   logic k_rise, kn_rise, c_rise, cn_rise, c_held;
   assign k_rise = warm && s2_reg[NS-1] && !s3_reg[NS-1];
   assign kn_rise = warm && s2_reg[NS-2] && !s3_reg[NS-2];
   assign c_rise = warm && s2_reg[NS-3] && !s3_reg[NS-3];
   assign cn_rise = warm && s2_reg[NS-4] && !s3_reg[NS-4];
   // Fixed-high output clocks select input clock timing
   assign c_held = s2_reg[NS-3] && s3_reg[NS-3] && s2_reg[NS-4] && s3_reg[NS-4];
   logic ref_pos, ref_neg;
   assign ref_pos = c_held ? k_rise : c_rise;
   assign ref_neg = c_held ? kn_rise : cn_rise;
   logic dll_n_s1_reg, dll_n_s2_reg;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dll_n_s1_reg <= `DSP_ONE_BIT;
         dll_n_s2_reg <= `DSP_ONE_BIT;
      end else begin
         dll_n_s1_reg <= delay_lock_disable_n_i;
         dll_n_s2_reg <= dll_n_s1_reg;
      end
   end
   assign dll_bypass_o = !dll_n_s2_reg;
   // ****************************************
   // Storage and lane writes
   // ****************************************
   localparam int LW = ORG_BITS / LANES;
   localparam int DEPTH = 1 << (ADDR_W + 1);
   logic [ORG_BITS-1:0] mem [DEPTH];
   logic wr_fire;
   logic [ADDR_W:0] wr_addr;
   dsp_pkg::dsp_word_t wr_word;
   dsp_pkg::dsp_word_t wr_word_reg;
   always_ff @(posedge core_clk_i) begin
      for (int g = 0; g < LANES; g++) begin
         if (wr_fire && !wr_word.lane_we[g]) begin
            mem[wr_addr][g*LW +: LW] <= wr_word.data[g*LW +: LW];
         end
      end
   end
   // ****************************************
   // Command state machine
   // ****************************************
   dsp_pkg::dsp_state_t st_reg, st_next;
   logic [ADDR_W-1:0] a_reg, a_next;
   logic b0_reg, b0_next;
   logic ph_reg, ph_next;
   logic wfire;
   logic wphase;
   logic burst_start_bit_i_s;
   dsp_pkg::dsp_word_t wbuf_in;
   always_comb begin
      st_next = st_reg;
      a_next = a_reg;
      b0_next = b0_reg;
      ph_next = ph_reg;
      wfire = 1'b0;
      wphase = 1'b0;
      wbuf_in.data = d_s;
      wbuf_in.lane_we = we_n_s;
      case (st_reg)
         dsp_pkg::DSP_WR0: begin
            if (k_rise) begin
               wfire = 1'b1;
               st_next = dsp_pkg::DSP_WR1;
            end
         end
         dsp_pkg::DSP_WR1: begin
            if (kn_rise) begin
               wfire = 1'b1;
               wphase = 1'b1;
               st_next = dsp_pkg::DSP_IDLE;
            end
         end
         default: begin
            // Idle and read both take commands at input_timing_pos rise
            if (k_rise && !ld_n_s) begin
               a_next = a_s;
               b0_next = burst_start_bit_i_s;
               st_next = rw_s ? dsp_pkg::DSP_RD : dsp_pkg::DSP_WR0;
               ph_next = 1'b0;
            end else if (k_rise) begin
               st_next = dsp_pkg::DSP_IDLE;
            end
         end
      endcase
   end
   logic bsb1_reg, bsb2_reg;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         bsb1_reg <= `DSP_ZERO_BIT;
         bsb2_reg <= `DSP_ZERO_BIT;
      end else begin
         bsb1_reg <= burst_start_bit_i;
         bsb2_reg <= bsb1_reg;
      end
   end
   assign burst_start_bit_i_s = bsb2_reg;
   logic wphase_reg;
   logic wb_valid;
   logic wb_ready;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_reg <= dsp_pkg::DSP_IDLE;
         a_reg <= '0;
         b0_reg <= `DSP_ZERO_BIT;
         ph_reg <= `DSP_ZERO_BIT;
         wphase_reg <= `DSP_ZERO_BIT;
      end else begin
         st_reg <= st_next;
         a_reg <= a_next;
         b0_reg <= b0_next;
         ph_reg <= ph_next;
         if (wfire) begin
            wphase_reg <= wphase;
         end
      end
   end
   // Burst word address: second word inverts the start bit
   logic [ADDR_W:0] waddr_hold_reg;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         waddr_hold_reg <= '0;
      end else if (wfire) begin
         waddr_hold_reg <= {a_reg, b0_reg ^ wphase};
      end
   end
   dsp_skid #(
      .W($bits(dsp_pkg::dsp_word_t))
   ) u_wbuf (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(wb_valid),
      .in_ready_o(),
      .in_data_i(wr_word_reg),
      .out_valid_o(wr_fire),
      .out_ready_i(1'b1),
      .out_data_o(wr_word)
   );
   logic wb_valid_reg;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wr_word_reg <= '0;
         wb_valid_reg <= `DSP_ZERO_BIT;
      end else begin
         wb_valid_reg <= wfire;
         if (wfire) begin
            wr_word_reg <= wbuf_in;
         end
      end
   end
   assign wb_valid = wb_valid_reg;
   assign wb_ready = 1'b1;
   assign wr_addr = waddr_hold_reg;
   // ****************************************
   // Read return and echo strobes
   // ****************************************
   logic [1:0] rcnt_reg, rcnt_next;
   logic [ORG_BITS-1:0] q_reg, q_next;
   logic oe_reg, oe_next;
   logic cq_reg, cq_next;
   always_comb begin
      rcnt_next = rcnt_reg;
      q_next = q_reg;
      oe_next = oe_reg;
      cq_next = cq_reg;
      if (ref_pos) begin
         cq_next = 1'b1;
      end else if (ref_neg) begin
         cq_next = 1'b0;
      end
      if (ref_neg && rcnt_reg == 2'd2) begin
         q_next = mem[{a_reg, b0_reg}];
         oe_next = 1'b1;
      end else if (ref_pos && rcnt_reg == 2'd1) begin
         q_next = mem[{a_reg, ~b0_reg}];
      end else if (ref_neg && rcnt_reg == 2'd0) begin
         oe_next = 1'b0;
      end
      if (ref_neg && rcnt_reg == 2'd2) begin
         rcnt_next = 2'd1;
      end else if (ref_pos && rcnt_reg == 2'd1) begin
         rcnt_next = 2'd0;
      end
      // New read wins over the last word of the previous burst
      if (k_rise && !ld_n_s && rw_s) begin
         rcnt_next = 2'd2;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rcnt_reg <= 2'd0;
         q_reg <= '0;
         oe_reg <= `DSP_ZERO_BIT;
         cq_reg <= `DSP_ZERO_BIT;
      end else begin
         rcnt_reg <= rcnt_next;
         q_reg <= q_next;
         oe_reg <= oe_next;
         cq_reg <= cq_next;
      end
   end
   assign dq_o = q_reg;
   assign dq_oe_o = oe_reg;
   assign data_valid_strobe_pos_o = cq_reg;
   assign data_valid_strobe_neg_o = !cq_reg;
endmodule
`default_nettype wire

// [dsp_defs.svh]
// Constants for the two-word burst SRAM port model.
// Assumes inclusion by the port, package, buffer and model files; definitions only.
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
`define DSP_ADDR_W 10
`define DSP_DATA_W 36
`define DSP_LANES 4
`define DSP_ZERO_BIT 1'b0
`define DSP_ONE_BIT 1'b1
`endif

// [dsp_pkg.sv]
// Types shared by the burst SRAM port.
// Assumes dsp_defs.svh is on the include path.
`include "dsp_defs.svh"
`default_nettype none
package dsp_pkg;
   typedef struct packed {
      logic [`DSP_DATA_W-1:0] data;
      logic [`DSP_LANES-1:0] lane_we;
   } dsp_word_t;
   typedef enum logic [1:0] {
      DSP_IDLE = 2'b00,
      DSP_WR0 = 2'b01,
      DSP_WR1 = 2'b10,
      DSP_RD = 2'b11
   } dsp_state_t;
endpackage
`default_nettype wire

// [dsp_skid.sv]
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock domain and synchronous active-high reset.
`include "dsp_defs.svh"
`default_nettype none
module dsp_skid #(
   parameter int W = `DSP_DATA_W
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic [W-1:0] mem_reg [2];
   logic [W-1:0] mem_next [2];
   logic [1:0] cnt_reg, cnt_next;
   logic rd_reg, rd_next, wr_reg, wr_next;
   logic push, pop;
   assign in_ready_o = (cnt_reg != 2'd2);
   assign out_valid_o = (cnt_reg != 2'd0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_comb begin
      mem_next = mem_reg;
      cnt_next = cnt_reg;
      rd_next = rd_reg;
      wr_next = wr_reg;
      if (push) begin
         mem_next[wr_reg] = in_data_i;
         wr_next = ~wr_reg;
      end
      if (pop) begin
         rd_next = ~rd_reg;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'd1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'd1;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 2'd0;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else begin
         cnt_reg <= cnt_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         mem_reg <= mem_next;
      end
   end
endmodule
`default_nettype wire

// [dsp_sram_port_monitor.sv]
// Pin checks for the burst SRAM port.
// Assumes one core clock domain; bound to the port at the foot.
`default_nettype none
module dsp_sram_port_monitor (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Watched pins
   input wire logic input_timing_pos_i,
   input wire logic input_timing_neg_i,
   input wire logic output_timing_pos_i,
   input wire logic output_timing_neg_i,
   input wire logic delay_lock_disable_n_i,
   input wire logic load_strobe_n_i,
   input wire logic read_not_write_i,
   input wire logic dq_oe_o,
   input wire logic data_valid_strobe_pos_o,
   input wire logic data_valid_strobe_neg_o,
   input wire logic dll_bypass_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pins_reg;
   logic [3:0] pins_next;
   logic [7:0] idle_reg;
   logic [7:0] idle_next;
   logic [7:0] age_reg;
   logic [7:0] age_next;
   // ****************
   // Edge age counters
   // ****************
   always_comb begin
      pins_next = {input_timing_pos_i, input_timing_neg_i, output_timing_pos_i, output_timing_neg_i};
      idle_next = (pins_next != pins_reg) ? 8'h00 : idle_reg + {7'h00, idle_reg != 8'hff};
      age_next = age_reg + {7'h00, age_reg != 8'hff};
      if (input_timing_pos_i && !pins_reg[3] && !load_strobe_n_i && read_not_write_i)
         age_next = 8'h00;
   end
   always_ff @(posedge core_clk_i) begin
      pins_reg <= pins_next;
      idle_reg <= sys_rst_i ? 8'h00 : idle_next;
      age_reg <= sys_rst_i ? 8'hff : age_next;
   end
   // ****************
   // Properties
   // ****************
   default clocking dcb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_init;
      $fell(sys_rst_i) |-> !dq_oe_o && !data_valid_strobe_pos_o && data_valid_strobe_neg_o;
   endproperty
   property p_cause;
      $rose(dq_oe_o) |-> age_reg inside {[6:16]};
   endproperty
   property p_len;
      $rose(dq_oe_o) |=> dq_oe_o [*8];
   endproperty
   property p_compl;
      data_valid_strobe_pos_o != data_valid_strobe_neg_o;
   endproperty
   property p_stop;
      idle_reg >= 8'h0a |-> $stable(data_valid_strobe_pos_o) && $stable(data_valid_strobe_neg_o);
   endproperty
   property p_follow;
      $changed(data_valid_strobe_pos_o) |-> idle_reg <= 8'h05;
   endproperty
   property p_drop;
      $fell(dq_oe_o) |-> idle_reg <= 8'h05;
   endproperty
   property p_byp;
      $fell(delay_lock_disable_n_i) |-> ##[1:4] dll_bypass_o;
   endproperty
   a_init: assert property (p_init) else $error("bad outputs after reset");
   a_cause: assert property (p_cause) else $error("bus driven without read");
   a_len: assert property (p_len) else $error("burst too short");
   a_compl: assert property (p_compl) else $error("strobes not complementary");
   a_stop: assert property (p_stop) else $error("strobe moved with clocks stopped");
   a_follow: assert property (p_follow) else $error("strobe moved off edge");
   a_drop: assert property (p_drop) else $error("bus released off edge");
   a_byp: assert property (p_byp) else $error("bypass flag late");
   c_read: cover property ($rose(dq_oe_o));
   c_kmode: cover property (output_timing_pos_i && output_timing_neg_i && dq_oe_o);
   c_stop: cover property (idle_reg == 8'h28);
endmodule
bind dsp_sram_port dsp_sram_port_monitor i_mon (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .input_timing_pos_i(input_timing_pos_i), .input_timing_neg_i(input_timing_neg_i),
   .output_timing_pos_i(output_timing_pos_i), .output_timing_neg_i(output_timing_neg_i),
   .delay_lock_disable_n_i(delay_lock_disable_n_i), .load_strobe_n_i(load_strobe_n_i),
   .read_not_write_i(read_not_write_i), .dq_oe_o(dq_oe_o),
   .data_valid_strobe_pos_o(data_valid_strobe_pos_o), .data_valid_strobe_neg_o(data_valid_strobe_neg_o),
   .dll_bypass_o(dll_bypass_o)
);
`default_nettype wire

// [dsp_ctl_model.sv]
// Memory controller model: link clocks, commands and write data.
// Assumes the bench calls one task at a time.
`include "dsp_defs.svh"
`default_nettype none
module dsp_ctl_model #(
   parameter int HOLD_NS = 12
) (
   // Link clocks
   output var logic k_o,
   output var logic kn_o,
   output logic c_o,
   output logic cn_o,
   // Command and data
   output var logic ld_n_o,
   output var logic rw_o,
   output var logic [`DSP_ADDR_W-1:0] addr_o,
   output var logic bsb_o,
   output var logic [`DSP_LANES-1:0] bwe_n_o,
   output var logic [`DSP_DATA_W-1:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run = 1'b1;
   logic hold_c = 1'b0;
   assign c_o = hold_c | k_o;
   assign cn_o = hold_c | kn_o;
   initial begin
      {k_o, kn_o, ld_n_o, rw_o, bsb_o} = 5'h0c;
      addr_o = '0;
      bwe_n_o = '1;
      dq_o = '0;
      forever begin
         #32;
         k_o = run & ~k_o;
         kn_o = run & ~k_o;
      end
   end
   task automatic cmd(input logic rd, input logic [`DSP_ADDR_W-1:0] a, input logic b);
      @(negedge k_o) #HOLD_NS;
      {ld_n_o, rw_o, bsb_o} = {1'b0, rd, b};
      addr_o = a;
      dq_o = ~dq_o;
   endtask
   task automatic wr(input logic [`DSP_ADDR_W-1:0] a, input logic b, input dsp_pkg::dsp_word_t w0,
                     input dsp_pkg::dsp_word_t w1);
      cmd(1'b0, a, b);
      nop(1);
      {dq_o, bwe_n_o} = w0;
      @(posedge k_o) #HOLD_NS;
      {dq_o, bwe_n_o} = w1;
   endtask
   task automatic nop(input int n);
      repeat (n) begin
         @(negedge k_o) #HOLD_NS;
         ld_n_o = 1'b1;
         addr_o = ~addr_o;
         dq_o = ~dq_o;
      end
   endtask
endmodule
`default_nettype wire

// [dsp_sram_port_tb_top.sv]
// Self-checking bench for the burst SRAM port.
// Assumes the controller model and the bound monitor are compiled.
`default_nettype none
module dsp_sram_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic dll_n = 1'b1;
   logic k, kn, c, cn, ld_n, rw, bsb, oe, sp, sn, byp;
   logic sp_q = 1'b0;
   logic sn_q = 1'b1;
   logic [9:0] addr;
   logic [3:0] bwe_n;
   logic [35:0] dqi, dq;
   logic [35:0] mem [int];
   logic [35:0] exp_q [$];
   logic [31:0] seed = 32'h8608_f88f;
   int fails = 0;
   int checks_done = 0;
   initial forever #2 core_clk_i = ~core_clk_i;
   dsp_ctl_model i_ctl (.k_o(k), .kn_o(kn), .c_o(c), .cn_o(cn), .ld_n_o(ld_n), .rw_o(rw), .addr_o(addr),
      .bsb_o(bsb), .bwe_n_o(bwe_n), .dq_o(dqi));
   dsp_sram_port i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .input_timing_pos_i(k),
      .input_timing_neg_i(kn), .output_timing_pos_i(c), .output_timing_neg_i(cn),
      .delay_lock_disable_n_i(dll_n), .load_strobe_n_i(ld_n), .read_not_write_i(rw), .addr_i(addr),
      .burst_start_bit_i(bsb), .byte_write_enable_n_i(bwe_n), .dq_i(dqi), .dq_o(dq), .dq_oe_o(oe),
      .data_valid_strobe_pos_o(sp), .data_valid_strobe_neg_o(sn), .dll_bypass_o(byp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d, input logic [3:0] m);
      for (int g = 0; g < 4; g++)
         if (!m[g]) old[g*9 +: 9] = d[g*9 +: 9];
      return old;
   endfunction
   task automatic complete_run();
      $display("TB: checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic b, input logic [3:0] m);
      logic [31:0] h;
      logic [35:0] d0;
      logic [35:0] d1;
      h = rnd();
      d0 = {h[3:0], rnd()};
      d1 = {h[7:4], rnd()};
      i_ctl.wr(a, b, {d0, m}, {d1, m});
      mem[{a, b}] = merge(mem[{a, b}], d0, m);
      mem[{a, ~b}] = merge(mem[{a, ~b}], d1, m);
   endtask
   task automatic rd(input logic [9:0] a, input logic b);
      i_ctl.cmd(1'b1, a, b);
      exp_q.push_back(mem[{a, b}]);
      exp_q.push_back(mem[{a, ~b}]);
   endtask
   task automatic drain(input string name);
      int n;
      i_ctl.nop(2);
      n = 0;
      while (exp_q.size() != 0 && n < 400) begin
         @(posedge core_clk_i);
         n++;
      end
      chk("words left", 36'h0_0000_0000, exp_q.size());
      if (exp_q.size() != 0)
         complete_run();
      $display("TB: test %s done", name);
   endtask
   always @(negedge core_clk_i) begin
      if (oe === 1'b1 && ((sp && !sp_q) || (sn && !sn_q)))
         chk("read word", exp_q.size() ? exp_q.pop_front() : 'x, dq);
      sp_q <= sp;
      sn_q <= sn;
   end
   initial begin
      #300000;
      fails++;
      complete_run();
   end
   initial begin
      int i;
      logic [31:0] r;
      logic [9:0] adr [8];
      logic [1:0] s;
      repeat (3) @(posedge core_clk_i);
      #1 sys_rst_i = 1'b0;
      @(posedge core_clk_i);
      #1 chk("reset outputs", 36'h0_0000_0002, {oe, sp, sn, byp});
      for (i = 0; i < 8; i++) begin
         r = rnd();
         adr[i] = r[9:0];
         wr(adr[i], i[0], 4'h0);
      end
      for (i = 0; i < 8; i++)
         rd(adr[i], ~i[0]);
      drain("write read");
      for (i = 0; i < 5; i++)
         wr(adr[i], 1'b1, ~(4'h1 << i));
      for (i = 0; i < 5; i++)
         rd(adr[i], 1'b0);
      drain("lanes");
      i_ctl.hold_c = 1'b1;
      rd(adr[5], 1'b0);
      rd(adr[6], 1'b1);
      drain("input clock reference");
      i_ctl.hold_c = 1'b0;
      @(posedge core_clk_i);
      #1 dll_n = 1'b0;
      repeat (6) @(posedge core_clk_i);
      #1 chk("bypass flag", 36'h0_0000_0001, byp);
      rd(adr[7], 1'b1);
      drain("bypass");
      @(posedge core_clk_i);
      #1 dll_n = 1'b1;
      i_ctl.run = 1'b0;
      repeat (30) @(posedge core_clk_i);
      s = {sp, sn};
      repeat (40) @(posedge core_clk_i);
      #1 chk("stopped strobes", s, {sp, sn});
      i_ctl.run = 1'b1;
      rd(adr[3], 1'b0);
      drain("clock stop");
      complete_run();
   end
endmodule
`default_nettype wire
